// *** hw/eipf_irq_flags.sv ***
/*
 * interrupt flag, enable and priority logic for three external pins and the
 * first peripheral request bank, with an APB register slave.
 * assumes peripheral event inputs are on clock; pins are asynchronous.
 */
// Design decisions made here: the APB register port and the register addresses.
`include "eipf_regs.svh"

module eipf_irq_flags #(
    parameter int ADDR_W  = 8,
    parameter int COUNT_W = 8
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               reset_n,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // external interrupt pins, a in bit 0
    input  wire logic [2:0]         ext_irq_pin,
    // peripheral events
    input  wire logic               conversion_done,
    input  wire logic               sync_port_done,
    input  wire logic               counter_a_overflow,
    input  wire logic [COUNT_W-1:0] counter_b_count,
    input  wire logic [COUNT_W-1:0] period_register,
    // serial receiver side
    input  wire logic               rx_data_valid,
    input  wire logic [7:0]         rx_data,
    // serial transmitter side
    output logic      [7:0]         tx_data,
    output logic                    tx_data_valid,
    input  wire logic               tx_data_take,
    // requests to the core
    output logic                    irq,
    output logic                    irq_high,
    output logic                    irq_low
);

    if (ADDR_W < 8 || COUNT_W < 1)
    begin : g_param_check
        $error("eipf_irq_flags: ADDR_W must be at least 8 and COUNT_W at least 1");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a[7:0] == off) && ((a >> 8) == '0);
    endfunction

    // bus phases; zero wait states, so every access phase completes
    logic setup_ph;
    logic acc;
    logic wr_lo;
    logic wr_hi;
    logic rd_acc;

    assign pready   = 1'b1;
    assign setup_ph = psel & ~penable;
    assign acc      = psel & penable;
    assign wr_lo    = acc & pwrite & pstrb[0];
    assign wr_hi    = acc & pwrite & pstrb[1];
    assign rd_acc   = acc & ~pwrite;

    // register state
    logic [1:0]               ext_prio_q;
    logic [2:0]               ext_en_q;
    logic [2:0]               ext_flag_q;
    eipf_pkg::eipf_flags_a_s  flags_q;
    eipf_pkg::eipf_config_s   cfg_q;
    logic [7:0]               periph_en_q;
    logic [7:0]               rx_buf_q;
    logic                     rx_full_q;
    logic [7:0]               tx_buf_q;
    logic                     tx_full_q;
    logic [31:0]              prdata_q;
    logic                     pslverr_q;

    // pin synchronisers and edge detection
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_prev_q;
    logic [2:0] ext_edge;

    for (genvar i = 0; i < 3; i++)
    begin : g_pin
        always_ff @(posedge clock)
        begin
            if (!reset_n)
            begin
                pin_s1_q[i]   <= 1'b0;
                pin_s2_q[i]   <= 1'b0;
                pin_prev_q[i] <= 1'b0;
            end
            else
            begin
                pin_s1_q[i]   <= ext_irq_pin[i];
                pin_s2_q[i]   <= pin_s1_q[i];
                pin_prev_q[i] <= pin_s2_q[i];
            end
        end

        assign ext_edge[i] = cfg_q.ext_irq_edge_select[i]
                           ? (pin_s2_q[i] & ~pin_prev_q[i])
                           : (~pin_s2_q[i] & pin_prev_q[i]);
    end

    // register views
    eipf_pkg::eipf_ext_ctrl_s ext_view;
    eipf_pkg::eipf_flags_a_s  flags_view;
    logic [`EIPF_STAT_W-1:0]  status;
    logic [`EIPF_STAT_W-1:0]  enables;
    logic [`EIPF_STAT_W-1:0]  prio;
    logic [`EIPF_STAT_W-1:0]  pending;
    logic [`EIPF_STAT_W-1:0]  clr_bits;

    assign ext_view = eipf_pkg::eipf_ext_ctrl_s'({ext_prio_q, ext_en_q, ext_flag_q});

    always_comb
    begin
        flags_view                      = flags_q;
        flags_view.serial_rx_full_flag  = rx_full_q;
        flags_view.serial_tx_empty_flag = ~tx_full_q;
    end

    // only bank a lives here; banks b and c sit in their own blocks
    assign status   = {ext_flag_q, 8'(flags_view) & `EIPF_FLAGS_A_IMPL};
    assign enables  = {ext_en_q, periph_en_q & `EIPF_FLAGS_A_IMPL};
    assign prio     = {cfg_q.ext_irq_c_priority, ext_prio_q, cfg_q.periph_priority};
    assign clr_bits = (wr_lo && hit(paddr, `EIPF_OFF_CLEAR))
                    ? `EIPF_STAT_W'(pwdata[10:0]) & {3'h7, 8'(`EIPF_FLAGS_A_STICKY)}
                    : '0;

    // interrupt requests
    assign pending  = status & enables;
    assign irq      = |pending;
    assign irq_high = cfg_q.global_irq_enable & |(pending & prio);
    assign irq_low  = cfg_q.global_irq_enable & |(pending & ~prio);

    // external control: priorities and enables, enables aliased in the enable word
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            ext_prio_q <= `EIPF_RST_EXT_PRIO;
            ext_en_q   <= `EIPF_RST_EXT_EN;
        end
        else if (wr_lo && hit(paddr, `EIPF_OFF_EXT_CTRL))
        begin
            ext_prio_q <= pwdata[7:6];
            ext_en_q   <= pwdata[5:3];
        end
        else if (wr_hi && hit(paddr, `EIPF_OFF_ENABLE))
        begin
            ext_en_q   <= pwdata[10:8];
        end
    end

    // external flags: an edge wins over a same-cycle clear
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            ext_flag_q <= `EIPF_RST_EXT_FLAG;
        end
        else if (wr_lo && hit(paddr, `EIPF_OFF_EXT_CTRL))
        begin
            ext_flag_q <= ext_edge | pwdata[2:0];
        end
        else
        begin
            ext_flag_q <= ext_edge | (ext_flag_q & ~clr_bits[10:8]);
        end
    end

    // sticky peripheral flags; the serial flags are derived, not stored
    eipf_pkg::eipf_flags_a_s fa_set;
    logic                    period_match;

    assign period_match = (counter_b_count == period_register);

    always_comb
    begin
        fa_set                         = '0;
        fa_set.conversion_done_flag    = conversion_done;
        fa_set.sync_port_done_flag     = sync_port_done;
        fa_set.period_match_flag       = period_match;
        fa_set.counter_a_overflow_flag = counter_a_overflow;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            flags_q <= `EIPF_RST_FLAGS_A;
        end
        else if (wr_lo && hit(paddr, `EIPF_OFF_FLAGS_A))
        begin
            flags_q <= (fa_set | pwdata[7:0]) & `EIPF_FLAGS_A_STICKY;
        end
        else
        begin
            flags_q <= (fa_set | (flags_q & ~clr_bits[7:0])) & `EIPF_FLAGS_A_STICKY;
        end
    end

    // configuration and peripheral enables
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            cfg_q <= `EIPF_RST_CONFIG;
        end
        else if (acc && pwrite && hit(paddr, `EIPF_OFF_CONFIG))
        begin
            if (pstrb[0])
            begin
                cfg_q[7:0] <= pwdata[7:0] & 8'h1F;
            end
            if (pstrb[1])
            begin
                cfg_q[15:8] <= pwdata[15:8];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            periph_en_q <= `EIPF_RST_PERIPH_EN;
        end
        else if (wr_lo && hit(paddr, `EIPF_OFF_ENABLE))
        begin
            periph_en_q <= pwdata[7:0] & `EIPF_FLAGS_A_IMPL;
        end
    end

    // receive buffer: new data wins over a same-cycle read
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            rx_buf_q  <= `EIPF_RST_BYTE;
            rx_full_q <= 1'b0;
        end
        else
        begin
            if (rx_data_valid)
            begin
                rx_buf_q <= rx_data;
            end
            rx_full_q <= rx_data_valid
                       | (rx_full_q & ~(rd_acc && hit(paddr, `EIPF_OFF_RX_BUF)));
        end
    end

    // transmit buffer: a write overwrites data not yet taken
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            tx_buf_q  <= `EIPF_RST_BYTE;
            tx_full_q <= 1'b0;
        end
        else if (wr_lo && hit(paddr, `EIPF_OFF_TX_BUF))
        begin
            tx_buf_q  <= pwdata[7:0];
            tx_full_q <= 1'b1;
        end
        else if (tx_data_take)
        begin
            tx_full_q <= 1'b0;
        end
    end

    assign tx_data       = tx_buf_q;
    assign tx_data_valid = tx_full_q;

    // read data is latched in the setup cycle so prdata comes from a flop
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            if (hit(paddr, `EIPF_OFF_EXT_CTRL))
            begin
                prdata_q <= 32'(ext_view);
            end
            else if (hit(paddr, `EIPF_OFF_FLAGS_A))
            begin
                prdata_q <= 32'(8'(flags_view) & `EIPF_FLAGS_A_IMPL);
            end
            else if (hit(paddr, `EIPF_OFF_CONFIG))
            begin
                prdata_q <= 32'(cfg_q);
            end
            else if (hit(paddr, `EIPF_OFF_STATUS))
            begin
                prdata_q <= 32'(status);
            end
            else if (hit(paddr, `EIPF_OFF_ENABLE))
            begin
                prdata_q <= 32'(enables);
            end
            else if (hit(paddr, `EIPF_OFF_RX_BUF))
            begin
                prdata_q <= 32'(rx_buf_q);
            end
            else if (!hit(paddr, `EIPF_OFF_CLEAR) && !hit(paddr, `EIPF_OFF_TX_BUF))
            begin
                pslverr_q <= 1'b1;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & acc;

    // checks
    a_edge_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
        ext_edge[1] |=> ext_flag_q[1])
        else $error("pin b edge did not set its flag");

    a_pin_c_sticky: assert property (@(posedge clock) disable iff (!reset_n)
        ext_flag_q[2] && !(wr_lo && hit(paddr, `EIPF_OFF_EXT_CTRL)) && !clr_bits[10]
        |=> ext_flag_q[2])
        else $error("pin c flag dropped without software");

    a_rising_edge: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_q.ext_irq_edge_select[0] && $rose(pin_s2_q[0]) |-> ##1 ext_flag_q[0])
        else $error("rising edge on pin a not flagged");

    a_conv_done_set: assert property (@(posedge clock) disable iff (!reset_n)
        conversion_done |=> flags_q.conversion_done_flag[*2] or
        (flags_q.conversion_done_flag ##1 1'b1))
        else $error("conversion done not flagged");

    a_period_match: assert property (@(posedge clock) disable iff (!reset_n)
        period_match |=> flags_q.period_match_flag)
        else $error("period match not flagged");

    a_rx_read_clear: assert property (@(posedge clock) disable iff (!reset_n)
        rd_acc && hit(paddr, `EIPF_OFF_RX_BUF) && !rx_data_valid
        |=> !status[`EIPF_POS_RX_FULL])
        else $error("receive flag not cleared by buffer read");

    a_tx_write_clear: assert property (@(posedge clock) disable iff (!reset_n)
        wr_lo && hit(paddr, `EIPF_OFF_TX_BUF)
        |=> !status[`EIPF_POS_TX_EMPTY] && tx_data_valid)
        else $error("transmit flag not cleared by buffer write");

    a_unused_zero: assert property (@(posedge clock) disable iff (!reset_n)
        status[7] == 1'b0 && status[2] == 1'b0)
        else $error("unimplemented flag bit reads one");

    a_prio_b_high: assert property (@(posedge clock) disable iff (!reset_n)
        ext_flag_q[1] && ext_en_q[1] && ext_prio_q[1] && cfg_q.global_irq_enable
        |-> irq_high)
        else $error("pin b high priority request missing");

    a_prio_a_low: assert property (@(posedge clock) disable iff (!reset_n)
        ext_flag_q[0] && ext_en_q[0] && !ext_prio_q[0] && cfg_q.global_irq_enable
        |-> irq_low)
        else $error("pin a low priority request missing");

    a_global_gate: assert property (@(posedge clock) disable iff (!reset_n)
        !cfg_q.global_irq_enable |-> !irq_high && !irq_low)
        else $error("request raised with global enable off");

    a_enable_blocks: assert property (@(posedge clock) disable iff (!reset_n)
        enables == '0 |-> !irq)
        else $error("interrupt raised with all enables off");

    a_overflow_set: assert property (@(posedge clock) disable iff (!reset_n)
        counter_a_overflow && !(wr_lo && hit(paddr, `EIPF_OFF_FLAGS_A))
        |=> flags_q.counter_a_overflow_flag)
        else $error("overflow not flagged");

endmodule // eipf_irq_flags

// *** hw/eipf_regs.svh ***
/*
 * register map, reset values and field masks of the external and peripheral
 * interrupt flag block.
 * assumes one aligned 32-bit word per register on an APB slave.
 */
`ifndef EIPF_REGS_SVH
`define EIPF_REGS_SVH

// byte offsets
`define EIPF_OFF_EXT_CTRL   8'h00
`define EIPF_OFF_FLAGS_A    8'h04
`define EIPF_OFF_CONFIG     8'h08
`define EIPF_OFF_STATUS     8'h0C
`define EIPF_OFF_CLEAR      8'h10
`define EIPF_OFF_ENABLE     8'h14
`define EIPF_OFF_RX_BUF     8'h18
`define EIPF_OFF_TX_BUF     8'h1C

// reset values
`define EIPF_RST_EXT_PRIO   2'h3
`define EIPF_RST_EXT_EN     3'h0
`define EIPF_RST_EXT_FLAG   3'h0
`define EIPF_RST_FLAGS_A    8'h00
`define EIPF_RST_CONFIG     16'hFF1E
`define EIPF_RST_PERIPH_EN  8'h00
`define EIPF_RST_BYTE       8'h00

// field positions and masks of the peripheral flag bank and the status word
`define EIPF_FLAGS_A_IMPL   8'h7B
`define EIPF_FLAGS_A_STICKY 8'h4B
`define EIPF_POS_RX_FULL    5
`define EIPF_POS_TX_EMPTY   4
`define EIPF_POS_EXT_BASE   8
`define EIPF_STAT_W         11

`endif

// *** hw/eipf_pkg.sv ***
/*
 * register layouts of the external and peripheral interrupt flag block.
 * assumes eipf_regs.svh supplies offsets, resets and masks.
 */
package eipf_pkg;

    typedef struct packed {
        logic ext_irq_b_priority;
        logic ext_irq_a_priority;
        logic ext_irq_c_enable;
        logic ext_irq_b_enable;
        logic ext_irq_a_enable;
        logic ext_irq_c_flag;
        logic ext_irq_b_flag;
        logic ext_irq_a_flag;
    } eipf_ext_ctrl_s;

    typedef struct packed {
        logic unused_7;
        logic conversion_done_flag;
        logic serial_rx_full_flag;
        logic serial_tx_empty_flag;
        logic sync_port_done_flag;
        logic unused_2;
        logic period_match_flag;
        logic counter_a_overflow_flag;
    } eipf_flags_a_s;

    typedef struct packed {
        logic [7:0] periph_priority;
        logic [2:0] unused;
        logic       ext_irq_c_priority;
        logic [2:0] ext_irq_edge_select;
        logic       global_irq_enable;
    } eipf_config_s;

endpackage

// *** verif/eipf_periph_model.sv ***
/*
 * model of the pins, peripheral event sources and serial side that face the
 * flag block.
 * assumes the bench calls its tasks from one process, just after a rising edge.
 */
module eipf_periph_model (
    // clock
    input  wire logic       clock,
    // pins and events
    output logic      [2:0] ext_irq_pin,
    output logic            conversion_done,
    output logic            sync_port_done,
    output logic            counter_a_overflow,
    output logic      [7:0] counter_b_count,
    output logic      [7:0] period_register,
    // serial side
    output logic            rx_data_valid,
    output logic      [7:0] rx_data,
    output logic            tx_data_take
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        ext_irq_pin        = 3'h0;
        conversion_done    = 1'b0;
        sync_port_done     = 1'b0;
        counter_a_overflow = 1'b0;
        counter_b_count    = 8'h00;
        period_register    = 8'h80;
        rx_data_valid      = 1'b0;
        rx_data            = 8'h00;
        tx_data_take       = 1'b0;
    end

    // one-cycle pulse; 0 conv, 1 sync, 2 overflow, 3 match, 4 rx byte, else take
    task fire(input int which, input logic [7:0] d);
        @(posedge clock);
        case (which)
            0: conversion_done <= 1'b1;
            1: sync_port_done <= 1'b1;
            2: counter_a_overflow <= 1'b1;
            3: counter_b_count <= period_register;
            4: rx_data_valid <= 1'b1;
            default: tx_data_take <= 1'b1;
        endcase
        rx_data <= d;
        @(posedge clock);
        conversion_done    <= 1'b0;
        sync_port_done     <= 1'b0;
        counter_a_overflow <= 1'b0;
        counter_b_count    <= 8'h00;
        rx_data_valid      <= 1'b0;
        tx_data_take       <= 1'b0;
        // released data shows the inverse so a stale byte cannot look valid
        rx_data            <= ~d;
    endtask

    task pin(input logic [2:0] v);
        @(posedge clock);
        ext_irq_pin <= v;
    endtask
endmodule // eipf_periph_model

// *** verif/eipf_irq_flags_bench.sv ***
/*
 * self-checking bench of the flag block: apb master tasks and scenarios.
 * assumes the peripheral model drives every event input.
 */
`include "eipf_regs.svh"

module eipf_irq_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, cnt, per, rxd, txd;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [2:0]  pins;
    logic        conv, sync, ovf, rxv, txv, take, irq, irq_high, irq_low;
    int          miscompares, checks;

    eipf_irq_flags eipf_irq_flags_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(pins),
        .conversion_done(conv), .sync_port_done(sync), .counter_a_overflow(ovf),
        .counter_b_count(cnt), .period_register(per), .rx_data_valid(rxv), .rx_data(rxd),
        .tx_data(txd), .tx_data_valid(txv), .tx_data_take(take), .irq(irq),
        .irq_high(irq_high), .irq_low(irq_low));

    eipf_periph_model eipf_periph_model_inst (.clock(clock), .ext_irq_pin(pins),
        .conversion_done(conv), .sync_port_done(sync), .counter_a_overflow(ovf),
        .counter_b_count(cnt), .period_register(per), .rx_data_valid(rxv), .rx_data(rxd),
        .tx_data_take(take));

    always #4 clock = ~clock;

    task give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // waits an edge first so a release and the next setup never share a step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic err);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken as they stand at the edge itself
        @(posedge clock iff pready === 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, r, er);
        chk(r, e, "read data");
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        er;
        apb(1'b1, a, d, r, er);
    endtask

    task irqs(input logic [2:0] e);
        #1;
        chk({29'h0, irq, irq_high, irq_low}, {29'h0, e}, "irq, high, low");
    endtask

    task t_reset;
        logic [31:0] r;
        logic        er;
        rd(`EIPF_OFF_EXT_CTRL, 32'h0000_00C0);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0010);
        rd(`EIPF_OFF_CONFIG, 32'h0000_FF1E);
        rd(`EIPF_OFF_ENABLE, 32'h0000_0000);
        wr(`EIPF_OFF_STATUS, 32'h0000_FFFF);
        rd(`EIPF_OFF_STATUS, 32'h0000_0010);
        apb(1'b0, 8'h20, 32'h0000_0000, r, er);
        chk({31'h0, er}, 32'h0000_0001, "unmapped error");
        irqs(3'h0);
    endtask

    task t_periph;
        for (int i = 0; i < 4; i++)
            eipf_periph_model_inst.fire(i, 8'h00);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_005B);
        wr(`EIPF_OFF_FLAGS_A, 32'h0000_0000);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0010);
        wr(`EIPF_OFF_FLAGS_A, 32'h0000_00FF);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_005B);
        wr(`EIPF_OFF_CLEAR, 32'h0000_004B);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0010);
        eipf_periph_model_inst.fire(2, 8'h00);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0011);
        wr(`EIPF_OFF_CLEAR, 32'h0000_0001);
    endtask

    task t_pins;
        eipf_periph_model_inst.pin(3'h7);
        repeat (4) @(posedge clock);
        rd(`EIPF_OFF_EXT_CTRL, 32'h0000_00C7);
        rd(`EIPF_OFF_STATUS, 32'h0000_0710);
        eipf_periph_model_inst.pin(3'h0);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_00C0);
        repeat (4) @(posedge clock);
        rd(`EIPF_OFF_EXT_CTRL, 32'h0000_00C0);
        wr(`EIPF_OFF_CONFIG, 32'h0000_FF10);
        eipf_periph_model_inst.pin(3'h7);
        repeat (4) @(posedge clock);
        rd(`EIPF_OFF_EXT_CTRL, 32'h0000_00C0);
        eipf_periph_model_inst.pin(3'h0);
        repeat (4) @(posedge clock);
        rd(`EIPF_OFF_EXT_CTRL, 32'h0000_00C7);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_00C0);
        rd(`EIPF_OFF_EXT_CTRL, 32'h0000_00C0);
    endtask

    task t_serial;
        eipf_periph_model_inst.fire(4, 8'hA5);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0030);
        rd(`EIPF_OFF_RX_BUF, 32'h0000_00A5);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0010);
        wr(`EIPF_OFF_FLAGS_A, 32'h0000_0000);
        wr(`EIPF_OFF_TX_BUF, 32'h0000_003C);
        #1;
        chk({23'h0, txv, txd}, 32'h0000_013C, "tx byte");
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0000);
        eipf_periph_model_inst.fire(5, 8'h00);
        rd(`EIPF_OFF_FLAGS_A, 32'h0000_0010);
    endtask

    task t_irq;
        // stale flags go first so enabling cannot raise an old request
        wr(`EIPF_OFF_CLEAR, 32'h0000_07FF);
        wr(`EIPF_OFF_ENABLE, 32'h0000_0040);
        irqs(3'h0);
        eipf_periph_model_inst.fire(0, 8'h00);
        irqs(3'h4);
        wr(`EIPF_OFF_CONFIG, 32'h0000_FF11);
        irqs(3'h6);
        wr(`EIPF_OFF_CONFIG, 32'h0000_BF11);
        irqs(3'h5);
        wr(`EIPF_OFF_CLEAR, 32'h0000_0040);
        irqs(3'h0);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_0049);
        irqs(3'h6);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_0009);
        irqs(3'h5);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_0092);
        irqs(3'h6);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_0012);
        irqs(3'h5);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_0002);
        irqs(3'h0);
        wr(`EIPF_OFF_EXT_CTRL, 32'h0000_0024);
        irqs(3'h6);
    endtask

    initial
    begin
        clock = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; pstrb = 4'hF;
        miscompares = 0;
        checks = 0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        t_reset;
        t_periph;
        t_pins;
        t_serial;
        t_irq;
        give_verdict;
    end

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #200000;
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict;
    end
endmodule // eipf_irq_flags_bench
